//--- pkg/ptm_pkg.sv
package ptm_pkg;
    localparam int unsigned CLK_HZ   = 25_000_000;
    localparam int unsigned MINUTE_S = 60;
    localparam int unsigned MIN_CYC  = CLK_HZ * MINUTE_S;
    // Busy cycles per percent point; one window is 100 points
    localparam int unsigned PT_CYC   = 250;
    localparam int unsigned PCT_FULL = 100;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_UP_THR = 8'h04;
    localparam logic [7:0] ADDR_DN_THR = 8'h08;
    localparam logic [7:0] ADDR_UP_MIN = 8'h0c;
    localparam logic [7:0] ADDR_DN_MIN = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    localparam logic [7:0] UP_THR_LO = 8'h32;
    localparam logic [7:0] UP_THR_HI = 8'h64;
    localparam logic [7:0] DN_GAP    = 8'h0a;
    localparam logic [5:0] HOLD_LO   = 6'h01;
    localparam logic [5:0] HOLD_HI   = 6'h3c;

    localparam logic [7:0] UP_THR_RST = 8'h50;
    localparam logic [7:0] DN_THR_RST = 8'h46;
    localparam logic [5:0] HOLD_RST   = 6'h05;

    // CTRL word: [8] dn_auto [7] fail_en [6] tod_en [5:4] uncond [3:2] policy [1:0] sec_link
    localparam int unsigned CTRL_W = 9;
    localparam int unsigned STAT_ACT_POS  = 0;
    localparam int unsigned STAT_PRI_POS  = 8;
    localparam int unsigned STAT_COMB_POS = 16;

    typedef enum logic [1:0] {
        POL_ALWAYS = 2'h0,
        POL_THRESH = 2'h1,
        POL_TOD    = 2'h2
    } ptm_policy_e;

    typedef enum logic [1:0] {
        ST_STBY = 2'b01,
        ST_ACT  = 2'b10
    } ptm_state_e;

    typedef struct packed {
        logic        dn_auto;
        logic        fail_en;
        logic        tod_en;
        logic [1:0]  uncond;
        ptm_policy_e policy;
        logic [1:0]  sec_link;
    } ptm_cfg_s;

    localparam ptm_cfg_s CTRL_RST = '{dn_auto: 1'b1, fail_en: 1'b0, tod_en: 1'b0,
        uncond: 2'h1, policy: POL_THRESH, sec_link: 2'h2};

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ptm_apb_req_s;
endpackage : ptm_pkg

//--- verilog/ptm_util_meter.sv
`timescale 1ns/100ps
module ptm_util_meter #(
    parameter int unsigned PT_CYC = ptm_pkg::PT_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic [1:0] weight_i,
    output logic      [7:0] pct_o
);
    import ptm_pkg::*;

    if (PT_CYC < 2 || PT_CYC > 65535) $error("PT_CYC out of range");

    logic [15:0] sub_r;
    logic [7:0]  acc_r;
    logic [7:0]  pt_r;
    logic [15:0] cyc_r;
    logic [15:0] sub_sum;
    wire         pt_hit = sub_sum >= 16'(PT_CYC);
    wire         cyc_end = cyc_r == 16'(PT_CYC - 1);
    wire         win_end = cyc_end && pt_r == 8'(PCT_FULL - 1);

    assign sub_sum = sub_r + 16'(weight_i);

    // Percentage is the busy-cycle total of one window divided by PT_CYC
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            sub_r <= 16'h0;
            acc_r <= 8'h0;
            pt_r  <= 8'h0;
            cyc_r <= 16'h0;
            pct_o <= 8'h0;
        end
        else
        begin
            sub_r <= pt_hit ? sub_sum - 16'(PT_CYC) : sub_sum;
            cyc_r <= cyc_end ? 16'h0 : cyc_r + 16'h1;
            pt_r  <= win_end ? 8'h0 : (cyc_end ? pt_r + 8'h1 : pt_r);
            acc_r <= win_end ? 8'h0 : acc_r + {7'h0, pt_hit};
            if (win_end)
                pct_o <= acc_r + {7'h0, pt_hit};
        end

    pct_bound_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        pct_o <= 8'd200) else $error("utilization above 200 percent");
endmodule : ptm_util_meter

//--- verilog/ptm_hold_timer.sv
`timescale 1ns/100ps
module ptm_hold_timer (
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       cond_i,
    input  wire logic       tick_i,
    input  wire logic [5:0] hold_i,
    output logic            done_o
);
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;

    // (R13) restart on drop
    // Ticks run free, so the first may come at once: hold+1 ticks give a full hold
    assign cnt_nxt = !cond_i ? 6'h0 : ((tick_i && cnt_r <= hold_i) ? cnt_r + 6'h1 : cnt_r);

    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            cnt_r  <= 6'h0;
            done_o <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            done_o <= cond_i && cnt_nxt > hold_i;
        end

    cnt_clear_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R13)
        !cond_i |=> cnt_r == 6'h0 && !done_o) else $error("hold count not cleared");
    done_cause_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R02)
        $rose(done_o) |-> $past(cond_i) && $past(tick_i)) else $error("done without tick");
endmodule : ptm_hold_timer

//--- verilog/ptm_standby_ctrl.sv
`timescale 1ns/100ps
// How it works
// (R01) Primary use in percent is compared with an activation level of 50..100.
// (R02) Standby starts after use stays above that level for 1..60 minutes.
// (R03) Activation raises the outgoing control line of the standby link.
// (R04) Deactivation lowers that control line so the call clears.
// (R05) Release level defaults to ten points below the activation level.
// (R06) Release compares both links' combined throughput against primary bandwidth.
// (R07) Standby stops after combined use stays below release for 1..60 minutes.
// (R08) Threshold activation needs a selected secondary link and threshold policy.
// (R09) While standby is active, traffic is shared over both links.
// (R10) After release the second link waits in standby for the next need.
// (R11) Time-of-day or primary failure may also bring the second link up.
// (R12) Each link is either unconditional or conditional.
// (R13) A broken hold period clears its minute count and restarts later.
module ptm_standby_ctrl #(
    parameter int unsigned MIN_CYC = ptm_pkg::MIN_CYC,
    parameter int unsigned PT_CYC  = ptm_pkg::PT_CYC
) (
    input  wire logic                ref_clk_i,
    input  wire logic                nrst_i,
    input  wire ptm_pkg::ptm_apb_req_s apb_i,
    input  wire logic                pri_busy_i,
    input  wire logic                sec_busy_i,
    input  wire logic                tod_active_i,
    input  wire logic                pri_fail_i,
    output logic [31:0]              prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    output logic [1:0]               link_ctl_o,
    output logic                     loadshare_o,
    output logic                     standby_active_o
);
    import ptm_pkg::*;

    if (MIN_CYC < 2) $error("MIN_CYC must be at least 2");

    function automatic logic [7:0] clamp8(input logic [7:0] v,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
        clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp8

    function automatic logic [1:0] link_mask(input logic [1:0] num);
        link_mask = (num == 2'h1) ? 2'b01 : ((num == 2'h2) ? 2'b10 : 2'b00);
    endfunction : link_mask

    ptm_cfg_s   cfg_r;
    logic [7:0] up_thr_r;
    logic [7:0] dn_thr_r;
    logic [5:0] up_min_r;
    logic [5:0] dn_min_r;
    ptm_state_e st_r;
    ptm_state_e st_nxt;
    logic [31:0] min_cnt_r;
    logic        tick_r;
    logic [7:0]  pri_pct;
    logic [7:0]  comb_pct;
    logic        up_done;
    logic        dn_done;

    // Bus decode
    wire        acc     = apb_i.psel && apb_i.penable;
    wire        done    = acc && pready_o;
    wire        wr      = done && apb_i.pwrite;
    wire [7:0]  a       = apb_i.paddr;
    wire        hit     = a == ADDR_CTRL || a == ADDR_UP_THR || a == ADDR_DN_THR
                       || a == ADDR_UP_MIN || a == ADDR_DN_MIN || a == ADDR_STATUS;
    wire [7:0]  wb      = apb_i.pwdata[7:0];
    wire [31:0] stat_w  = (32'(comb_pct) << STAT_COMB_POS) | (32'(pri_pct) << STAT_PRI_POS)
                        | (32'(st_r == ST_ACT) << STAT_ACT_POS);
    wire [31:0] rd_mux  = (a == ADDR_CTRL)   ? 32'(cfg_r)    :
                          (a == ADDR_UP_THR) ? 32'(up_thr_r) :
                          (a == ADDR_DN_THR) ? 32'(dn_thr_r) :
                          (a == ADDR_UP_MIN) ? 32'(up_min_r) :
                          (a == ADDR_DN_MIN) ? 32'(dn_min_r) :
                          (a == ADDR_STATUS) ? stat_w : 32'h0;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end
        else
        begin
            pready_o  <= acc && !pready_o;
            pslverr_o <= acc && !pready_o && !hit;
            prdata_o  <= (acc && !pready_o && !apb_i.pwrite) ? rd_mux : 32'h0;
        end

    // Register writes, out-of-range level and minute values clamp to the legal span; CTRL is stored unchecked
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            cfg_r    <= CTRL_RST;
            up_thr_r <= UP_THR_RST;
            dn_thr_r <= DN_THR_RST;
            up_min_r <= HOLD_RST;
            dn_min_r <= HOLD_RST;
        end
        else if (wr)
        begin
            if (a == ADDR_CTRL)
                cfg_r <= ptm_cfg_s'(apb_i.pwdata[CTRL_W-1:0]);
            // (R01) activation level span
            if (a == ADDR_UP_THR)
                up_thr_r <= clamp8(wb, UP_THR_LO, UP_THR_HI);
            if (a == ADDR_DN_THR)
                dn_thr_r <= clamp8(wb, 8'h0, UP_THR_HI);
            // (R02) (R07) minute span
            if (a == ADDR_UP_MIN)
                up_min_r <= 6'(clamp8(wb, 8'(HOLD_LO), 8'(HOLD_HI)));
            if (a == ADDR_DN_MIN)
                dn_min_r <= 6'(clamp8(wb, 8'(HOLD_LO), 8'(HOLD_HI)));
        end

    // Minute time base
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            min_cnt_r <= 32'h0;
            tick_r    <= 1'b0;
        end
        else
        begin
            min_cnt_r <= (min_cnt_r == 32'(MIN_CYC - 1)) ? 32'h0 : min_cnt_r + 32'h1;
            tick_r    <= min_cnt_r == 32'(MIN_CYC - 1);
        end

    // (R01) primary use in percent
    ptm_util_meter #(.PT_CYC(PT_CYC)) u_pri_meter (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .weight_i  ({1'b0, pri_busy_i}),
        .pct_o     (pri_pct)
    );

    // (R06) both links against primary bandwidth
    ptm_util_meter #(.PT_CYC(PT_CYC)) u_comb_meter (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .weight_i  (2'(pri_busy_i) + 2'(sec_busy_i)),
        .pct_o     (comb_pct)
    );

    wire [1:0] sec_mask = link_mask(cfg_r.sec_link);
    // (R08) (R12) threshold gate needs a conditional secondary link
    wire       bod_ok   = sec_mask != 2'b00 && cfg_r.policy == POL_THRESH
                       && (sec_mask & cfg_r.uncond) == 2'b00;
    // (R05) automatic release level
    wire [7:0] dn_level = cfg_r.dn_auto ? up_thr_r - DN_GAP : dn_thr_r;
    wire       up_cond  = bod_ok && st_r == ST_STBY && pri_pct > up_thr_r;
    // (R06) release compares combined use
    wire       dn_cond  = bod_ok && st_r == ST_ACT && comb_pct < dn_level;
    // (R11) time-of-day and failure causes
    wire       force_up = sec_mask != 2'b00 && (sec_mask & cfg_r.uncond) == 2'b00
                       && ((cfg_r.tod_en && tod_active_i) || (cfg_r.fail_en && pri_fail_i));

    // (R02) activation hold
    ptm_hold_timer u_up_hold (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .cond_i    (up_cond),
        .tick_i    (tick_r),
        .hold_i    (up_min_r),
        .done_o    (up_done)
    );

    // (R07) release hold
    ptm_hold_timer u_dn_hold (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .cond_i    (dn_cond),
        .tick_i    (tick_r),
        .hold_i    (dn_min_r),
        .done_o    (dn_done)
    );

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_STBY:
                if (force_up || (up_done && up_cond))
                    st_nxt = ST_ACT;
            // (R10) return to standby until needed again
            ST_ACT:
                if (!force_up && (!bod_ok || dn_done))
                    st_nxt = ST_STBY;
            default:
                st_nxt = ST_STBY;
        endcase
    end

    wire       act_nxt = st_nxt == ST_ACT;
    // (R03) (R04) (R12) control line per link
    wire [1:0] ctl_nxt = cfg_r.uncond | (act_nxt ? sec_mask : 2'b00)
                       | ((cfg_r.tod_en && tod_active_i) ? ~sec_mask : 2'b00);

    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            st_r             <= ST_STBY;
            link_ctl_o       <= 2'b00;
            loadshare_o      <= 1'b0;
            standby_active_o <= 1'b0;
        end
        else
        begin
            st_r             <= st_nxt;
            link_ctl_o       <= ctl_nxt;
            // (R09) share traffic while active
            loadshare_o      <= act_nxt;
            standby_active_o <= act_nxt;
        end

    sequence s_up_ready;
        st_r == ST_STBY && up_done && up_cond;
    endsequence

    sequence s_dn_ready;
        st_r == ST_ACT && dn_done && !force_up;
    endsequence

    up_start_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R02)
        s_up_ready |=> st_r == ST_ACT && standby_active_o) else $error("standby did not start");
    dn_stop_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R07)
        s_dn_ready |=> st_r == ST_STBY) else $error("standby did not stop");
    ctl_raise_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R03)
        $rose(standby_active_o) |-> (link_ctl_o & sec_mask) == sec_mask)
        else $error("control line not raised");
    ctl_drop_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R04)
        $fell(standby_active_o) && !cfg_r.tod_en && (sec_mask & cfg_r.uncond) == 2'b00
        && !$past(wr) |-> (link_ctl_o & sec_mask) == 2'b00) else $error("control line held");
    up_cause_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R08)
        $rose(standby_active_o) |-> $past(force_up) || $past(up_done && bod_ok))
        else $error("standby raised without cause");
    dn_level_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R05)
        cfg_r.dn_auto |-> dn_level + DN_GAP == up_thr_r) else $error("release level wrong");
    thr_span_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R01)
        up_thr_r >= UP_THR_LO && up_thr_r <= UP_THR_HI) else $error("activation level range");
    min_span_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R07)
        dn_min_r >= HOLD_LO && dn_min_r <= HOLD_HI && up_min_r >= HOLD_LO
        && up_min_r <= HOLD_HI) else $error("hold minutes range");
    share_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R09)
        loadshare_o == (st_r == ST_ACT)) else $error("load share mismatch");
    fail_up_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R11)
        st_r == ST_STBY && force_up |=> standby_active_o && st_r == ST_ACT)
        else $error("forced activation missed");
    force_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // (R11)
        st_r == ST_ACT && force_up |=> standby_active_o) else $error("forced link released");
    rdy_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        pready_o |=> !pready_o) else $error("pready longer than one cycle");
endmodule : ptm_standby_ctrl

//--- dv/ptm_modem_model.sv
`timescale 1ns/100ps
module ptm_modem_model #(
    parameter int unsigned CONN_DLY = 8
) (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic ctl_i,
    output logic      busy_o
);
    int unsigned dial_r;
    logic        up_r;

    // dial on raised control line, hang up as soon as it drops
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dial_r <= 0;
            up_r   <= 1'b0;
            busy_o <= 1'b0;
        end
        else
        begin
            dial_r <= ctl_i ? ((dial_r < CONN_DLY) ? dial_r + 1 : dial_r) : 0;
            up_r   <= ctl_i && (dial_r >= CONN_DLY);
            // Half-rate traffic keeps combined use below the release level
            busy_o <= up_r & ~busy_o;
        end
    end
endmodule : ptm_modem_model

//--- dv/ptm_standby_ctrl_tb.sv
`timescale 1ns/100ps
module ptm_standby_ctrl_tb;
    import ptm_pkg::*;
    localparam int unsigned T_MIN = 50;
    localparam int unsigned T_PT  = 2;
    // Whole sequence needs about 1500 cycles
    localparam int          LIMIT = 20000;

    logic         ref_clk;
    logic         nrst_n;
    ptm_apb_req_s apb;
    logic         pri_busy;
    logic         sec_busy;
    logic         tod_act;
    logic         pri_fail;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [1:0]   link_ctl;
    logic         loadshare;
    logic         stby_act;
    int           bad_count;
    int           checks;
    int           cyc;
    logic [31:0]  rd;
    logic         err;
    logic [7:0]   ra [5] = '{ADDR_CTRL, ADDR_UP_THR, ADDR_DN_THR, ADDR_UP_MIN, ADDR_DN_MIN};
    logic [31:0]  rv [5] = '{32'h116, 32'h50, 32'h46, 32'h5, 32'h5};

    ptm_standby_ctrl #(.MIN_CYC(T_MIN), .PT_CYC(T_PT)) u_ptm_standby_ctrl (
        .ref_clk_i(ref_clk), .nrst_i(nrst_n), .apb_i(apb), .pri_busy_i(pri_busy),
        .sec_busy_i(sec_busy), .tod_active_i(tod_act), .pri_fail_i(pri_fail),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link_ctl_o(link_ctl),
        .loadshare_o(loadshare), .standby_active_o(stby_act));

    ptm_modem_model u_ptm_modem_model (
        .ref_clk_i(ref_clk), .nrst_i(nrst_n), .ctl_i(link_ctl[1]), .busy_o(sec_busy));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Request held until pready is seen at an edge; data taken at that edge
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge ref_clk);
        apb.penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb <= '0;
    endtask : apb_xfer

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb_xfer(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, e});
    endtask : rd_chk

    task automatic wait_act(input logic v, input int n);
        for (int i = 0; i < n && stby_act !== v; i++)
            @(posedge ref_clk);
        chk({31'h0, stby_act}, {31'h0, v});
    endtask : wait_act

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            $display("MISMATCH %0t run did not finish", $time);
            end_sim();
        end
    end

    initial
    begin
        apb = '0;
        pri_busy = 1'b0;
        tod_act = 1'b0;
        pri_fail = 1'b0;
        nrst_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        nrst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({30'h0, link_ctl}, 32'h1);
        for (int i = 0; i < 5; i++)
            rd_chk(ra[i], rv[i], 1'b0);
        rd_chk(8'h18, 32'h0, 1'b1);
        apb_xfer(1'b1, ADDR_UP_THR, 32'h20);
        rd_chk(ADDR_UP_THR, 32'h32, 1'b0);
        apb_xfer(1'b1, ADDR_UP_THR, 32'hff);
        rd_chk(ADDR_UP_THR, 32'h64, 1'b0);
        apb_xfer(1'b1, ADDR_UP_MIN, 32'h0);
        rd_chk(ADDR_UP_MIN, 32'h1, 1'b0);
        apb_xfer(1'b1, ADDR_UP_MIN, 32'h3f);
        rd_chk(ADDR_UP_MIN, 32'h3c, 1'b0);
        apb_xfer(1'b1, ADDR_UP_THR, 32'h50);
        apb_xfer(1'b1, ADDR_UP_MIN, 32'h2);
        apb_xfer(1'b1, ADDR_DN_MIN, 32'h1);
        // Policy set to always, so threshold activation must stay off
        apb_xfer(1'b1, ADDR_CTRL, 32'h112);
        @(posedge ref_clk);
        pri_busy <= 1'b1;
        repeat (700) @(posedge ref_clk);
        chk({31'h0, stby_act}, 32'h0);
        apb_xfer(1'b1, ADDR_CTRL, 32'h116);
        // Two minutes of 50 cycles must pass before the link starts
        repeat (90) @(posedge ref_clk);
        chk({31'h0, stby_act}, 32'h0);
        wait_act(1'b1, 600);
        @(posedge ref_clk);
        chk({30'h0, link_ctl}, 32'h3);
        chk({31'h0, loadshare}, 32'h1);
        apb_xfer(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'hffff, 32'h6401);
        chk({31'h0, rd[23:16] >= 8'h64}, 32'h1);
        chk({31'h0, err}, 32'h0);
        pri_busy <= 1'b0;
        wait_act(1'b0, 800);
        @(posedge ref_clk);
        chk({30'h0, link_ctl}, 32'h1);
        chk({31'h0, loadshare}, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            apb_xfer(1'b1, ADDR_CTRL, (i == 0) ? 32'h156 : 32'h196);
            @(posedge ref_clk);
            tod_act <= (i == 0);
            pri_fail <= (i == 1);
            wait_act(1'b1, 5);
            @(posedge ref_clk);
            tod_act <= 1'b0;
            pri_fail <= 1'b0;
            wait_act(1'b0, 600);
        end
        apb_xfer(1'b1, ADDR_CTRL, 32'h136);
        repeat (3) @(posedge ref_clk);
        chk({30'h0, link_ctl}, 32'h3);
        apb_xfer(1'b1, ADDR_CTRL, 32'h116);
        repeat (3) @(posedge ref_clk);
        chk({30'h0, link_ctl}, 32'h1);
        end_sim();
    end
endmodule : ptm_standby_ctrl_tb
